// >>> src/dwc_write_exec.sv
// Write command executor: chaining checks, field sequencing, status
`timescale 1ns/1ps
module dwc_write_exec
   import dwc_pkg::*;
#(
   parameter logic [15:0] GAP1_LEN = 16'h0020,
   parameter logic [7:0] SRC_ID = 8'h5A // Arbitrary value
)(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic cmd_valid_i,
   input wire logic [7:0] cmd_code_i,
   input wire logic [15:0] cmd_count_i,
   input wire logic chain_i,
   input wire logic [7:0] chain_prev_i,
   input wire logic [7:0] chain_srch_i,
   input wire logic chain_match_i,
   input wire logic file_mask_hdr_i,
   input wire logic [7:0] rec_key_length_i,
   input wire logic [15:0] rec_data_length_i,
   input wire logic ch_valid_i,
   input wire logic [7:0] ch_data_i,
   input wire logic index_i,
   input wire logic bit_trig_i,
   output logic ch_req_o,
   output logic busy_o,
   output logic status_valid_o,
   output logic chan_end_o,
   output logic dev_end_o,
   output logic unit_check_o,
   output logic wr_gate_o,
   output logic addr_mark_o,
   output logic wr_bit_o,
   output logic wr_bit_valid_o
);
   // ****************************************
   // Types and state
   // ****************************************
   typedef enum logic [10:0] {
      ST_IDLE = 11'h001,
      ST_CHK = 11'h002,
      ST_WIDX = 11'h004,
      ST_GAP = 11'h008,
      ST_FLAG = 11'h010,
      ST_FIELD = 11'h020,
      ST_ECC1 = 11'h040,
      ST_ECC2 = 11'h080,
      ST_SRC = 11'h100,
      ST_DRAIN = 11'h200,
      ST_PAD = 11'h400
   } dwc_st_type;

   typedef struct packed {
      dwc_st_type st;
      dwc_fld_type fld;
      logic [7:0] code;
      logic [15:0] len;
      logic [15:0] xfer;
      logic [7:0] key_length;
      logic [15:0] data_length;
      logic [7:0] byte_hold;
      logic have;
      logic first;
      logic erase;
      logic [7:0] ecc_lo;
      logic req;
      logic busy;
      logic stat;
      logic ce;
      logic de;
      logic uc;
      logic gate;
      logic am;
   } dwc_state_type;

   dwc_state_type s_ff, nxt_s;
   logic ser_load, ser_rdy, ser_tag, ecc_clr, ser_bit, ser_vld, ser_btag;
   logic [7:0] ser_byte;
   logic [15:0] ecc;
   logic acc;

   generate
      if (GAP1_LEN == 16'h0000) begin : g_chk
         $error("GAP1_LEN must be at least one byte");
      end
   endgenerate

   // ****************************************
   // Chaining checks
   // ****************************************
   function automatic logic is_cmd(input logic [7:0] c, input logic [7:0] ref_c);
      return (c & CMD_MASK) == ref_c;
   endfunction

   function automatic logic eq_srch(input logic [7:0] c);
      return is_cmd(c, SRCH_ID_EQ) || is_cmd(c, SRCH_KEY_EQ);
   endfunction

   // ID or key equal search, directly or with a data read in between
   function automatic logic srch_ok(input logic [7:0] prev, input logic [7:0] srch,
                                    input logic match);
      return match && eq_srch(srch) &&
             (prev == srch || is_cmd(prev, RD_DATA) || is_cmd(prev, RD_KD));
   endfunction

   // Acceptance of the held command
   always_comb begin
      case (s_ff.code)
         WR_DATA: acc = chain_i && chain_match_i && eq_srch(chain_prev_i);
         WR_KD: acc = chain_i && chain_match_i && is_cmd(chain_prev_i, SRCH_ID_EQ);
         WR_CKD: acc = chain_i && (chain_prev_i == WR_R0 || chain_prev_i == WR_CKD ||
                       srch_ok(chain_prev_i, chain_srch_i, chain_match_i));
         WR_OVF: acc = chain_i && (chain_prev_i == WR_CKD ||
                       srch_ok(chain_prev_i, chain_srch_i, chain_match_i));
         WR_R0: acc = chain_i && (chain_prev_i == WR_HDR ||
                      (chain_match_i && is_cmd(chain_prev_i, SRCH_HDR_EQ)));
         WR_HDR: acc = file_mask_hdr_i;
         ERASE: acc = chain_i && (chain_prev_i == WR_R0 || chain_prev_i == WR_CKD ||
                      (chain_match_i && eq_srch(chain_prev_i)));
         default: acc = 1'b0;
      endcase
   end

   // ****************************************
   // Sequencer
   // ****************************************
   always_comb begin
      nxt_s = s_ff;
      nxt_s.stat = 1'b0;
      nxt_s.am = 1'b0;
      ser_load = 1'b0;
      ser_byte = ZERO_BYTE;
      ser_tag = 1'b0;
      ecc_clr = 1'b0;
      case (s_ff.st)
         ST_IDLE: begin
            nxt_s.ce = 1'b0;
            nxt_s.de = 1'b0;
            nxt_s.uc = 1'b0;
            if (cmd_valid_i) begin
               nxt_s.code = cmd_code_i;
               nxt_s.xfer = cmd_count_i;
               nxt_s.busy = 1'b1;
               nxt_s.st = ST_CHK;
            end
         end
         ST_CHK: begin
            nxt_s.first = 1'b1;
            nxt_s.have = 1'b0;
            nxt_s.erase = 1'b0;
            nxt_s.key_length = rec_key_length_i;
            nxt_s.data_length = rec_data_length_i;
            if (!acc) begin
               // Initial status only, no transfer and no gate
               nxt_s.stat = 1'b1;
               nxt_s.uc = 1'b1;
               nxt_s.busy = 1'b0;
               nxt_s.st = ST_IDLE;
            end else begin
               nxt_s.gate = s_ff.code != WR_HDR;
               case (s_ff.code)
                  WR_DATA: begin
                     nxt_s.fld = FLD_DATA;
                     nxt_s.len = rec_data_length_i;
                     nxt_s.st = ST_FIELD;
                  end
                  WR_KD: begin
                     nxt_s.fld = (rec_key_length_i == 8'h00) ? FLD_DATA : FLD_KEY;
                     nxt_s.len = (rec_key_length_i == 8'h00) ? rec_data_length_i :
                                 {8'h00, rec_key_length_i};
                     nxt_s.st = ST_FIELD;
                  end
                  WR_HDR: nxt_s.st = ST_WIDX;
                  ERASE: begin
                     nxt_s.erase = 1'b1;
                     nxt_s.fld = FLD_DATA;
                     nxt_s.len = s_ff.xfer;
                     nxt_s.st = ST_FIELD;
                  end
                  default: begin
                     nxt_s.am = 1'b1;
                     nxt_s.st = ST_FLAG;
                  end
               endcase
            end
         end
         ST_WIDX: begin
            if (index_i) begin
               nxt_s.gate = 1'b1;
               nxt_s.len = GAP1_LEN;
               nxt_s.st = ST_GAP;
            end
         end
         ST_GAP, ST_PAD: begin
            // Gap bytes and track padding are untagged zeros
            if (ser_rdy) begin
               ser_load = 1'b1;
               nxt_s.len = s_ff.len - 16'h0001;
            end
            if (s_ff.st == ST_GAP && ser_rdy && s_ff.len == 16'h0001) begin
               nxt_s.fld = FLD_HDR;
               nxt_s.len = HDR_LEN;
               nxt_s.st = ST_FIELD;
            end
            if (s_ff.st == ST_PAD && index_i) begin
               nxt_s.gate = 1'b0;
               nxt_s.busy = 1'b0;
               nxt_s.st = ST_IDLE;
            end
         end
         ST_FLAG: begin
            if (ser_rdy) begin
               ser_load = 1'b1;
               ser_tag = 1'b1;
               ecc_clr = 1'b1;
               ser_byte = FLAG_BASE;
               ser_byte[FLAG_OVF_BIT] = (s_ff.code == WR_OVF);
               nxt_s.first = 1'b0;
               nxt_s.fld = FLD_CNT;
               nxt_s.len = CNT_LEN;
               nxt_s.st = ST_FIELD;
            end
         end
         ST_FIELD: begin
            if (s_ff.len == 16'h0000) begin
               nxt_s.req = 1'b0;
               nxt_s.st = s_ff.erase ? ST_DRAIN : ST_ECC1;
            end else begin
               if (s_ff.have && ser_rdy) begin
                  ser_load = 1'b1;
                  ser_byte = s_ff.byte_hold;
                  ser_tag = 1'b1;
                  ecc_clr = s_ff.first;
                  nxt_s.first = 1'b0;
                  nxt_s.have = 1'b0;
                  nxt_s.len = s_ff.len - 16'h0001;
                  if (s_ff.fld == FLD_CNT) begin
                     // Key and data lengths come from the count area
                     if (s_ff.len == CNT_KEY_LEFT) nxt_s.key_length = s_ff.byte_hold;
                     if (s_ff.len == CNT_DLH_LEFT) nxt_s.data_length[15:8] = s_ff.byte_hold;
                     if (s_ff.len == CNT_DLL_LEFT) nxt_s.data_length[7:0] = s_ff.byte_hold;
                  end
               end else if (!s_ff.have) begin
                  if (s_ff.xfer == 16'h0000) begin
                     nxt_s.byte_hold = ZERO_BYTE;
                     nxt_s.have = 1'b1;
                  end else if (s_ff.req && ch_valid_i) begin
                     nxt_s.byte_hold = s_ff.erase ? ZERO_BYTE : ch_data_i;
                     nxt_s.have = 1'b1;
                     nxt_s.req = 1'b0;
                     nxt_s.xfer = s_ff.xfer - 16'h0001;
                  end else begin
                     nxt_s.req = 1'b1;
                  end
               end
            end
         end
         ST_ECC1: begin
            if (ser_rdy) begin
               ser_load = 1'b1;
               ser_byte = ecc[15:8];
               nxt_s.ecc_lo = ecc[7:0];
               nxt_s.st = ST_ECC2;
            end
         end
         ST_ECC2: begin
            if (ser_rdy) begin
               ser_load = 1'b1;
               ser_byte = s_ff.ecc_lo;
               nxt_s.first = 1'b1;
               case (s_ff.fld)
                  FLD_CNT: begin
                     nxt_s.fld = (s_ff.key_length == 8'h00) ? FLD_DATA : FLD_KEY;
                     nxt_s.len = (s_ff.key_length == 8'h00) ? s_ff.data_length :
                                 {8'h00, s_ff.key_length};
                     nxt_s.st = ST_FIELD;
                  end
                  FLD_KEY: begin
                     nxt_s.fld = FLD_DATA;
                     nxt_s.len = s_ff.data_length;
                     nxt_s.st = ST_FIELD;
                  end
                  FLD_HDR: nxt_s.st = ST_SRC;
                  default: nxt_s.st = ST_DRAIN;
               endcase
            end
         end
         ST_SRC: begin
            if (ser_rdy) begin
               ser_load = 1'b1;
               ser_byte = SRC_ID;
               nxt_s.st = ST_DRAIN;
            end
         end
         ST_DRAIN: begin
            // Ending status once the last bit (ECC, source byte or erase zero) has left the serializer
            if (ser_rdy) begin
               nxt_s.stat = 1'b1;
               nxt_s.ce = 1'b1;
               nxt_s.de = 1'b1;
               if (s_ff.erase) begin
                  nxt_s.st = ST_PAD;
               end else begin
                  nxt_s.gate = 1'b0;
                  nxt_s.busy = 1'b0;
                  nxt_s.st = ST_IDLE;
               end
            end
         end
         default: nxt_s.st = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         s_ff <= '0;
         s_ff.st <= ST_IDLE;
      end else begin
         s_ff <= nxt_s;
      end
   end

   // ****************************************
   // Serializer and correction code
   // ****************************************
   dwc_serializer u_ser (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .trig_i(bit_trig_i),
      .load_i(ser_load),
      .byte_i(ser_byte),
      .tag_i(ser_tag),
      .ready_o(ser_rdy),
      .bit_o(ser_bit),
      .bit_valid_o(ser_vld),
      .tag_o(ser_btag)
   );

   dwc_ecc_gen u_ecc (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .clr_i(ecc_clr),
      .bit_i(ser_bit),
      .bit_valid_i(ser_vld),
      .tag_i(ser_btag),
      .ecc_o(ecc)
   );

   // Outputs straight from flops
   assign ch_req_o = s_ff.req;
   assign busy_o = s_ff.busy;
   assign status_valid_o = s_ff.stat;
   assign chan_end_o = s_ff.ce;
   assign dev_end_o = s_ff.de;
   assign unit_check_o = s_ff.uc;
   assign wr_gate_o = s_ff.gate;
   assign addr_mark_o = s_ff.am;
   assign wr_bit_o = ser_bit;
   assign wr_bit_valid_o = ser_vld;

   // ****************************************
   // Assertions
   // ****************************************
   rej_quiet_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      status_valid_o && unit_check_o |-> !wr_gate_o && !ch_req_o && !chan_end_o)
      else $error("rejected command touched the track");
   end_pair_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      status_valid_o && !unit_check_o |-> chan_end_o && dev_end_o && $past(ser_rdy))
      else $error("ending status not paired after ECC");
   upd_chain_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      s_ff.st == ST_CHK && s_ff.code == WR_DATA && !eq_srch(chain_prev_i)
      |=> status_valid_o && unit_check_o)
      else $error("bad data update chain accepted");
   hdr_mask_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      s_ff.st == ST_CHK && s_ff.code == WR_HDR && !file_mask_hdr_i |=> unit_check_o)
      else $error("header write without file mask accepted");
   erase_twice_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      s_ff.st == ST_CHK && s_ff.code == ERASE && chain_prev_i == ERASE |=> unit_check_o)
      else $error("erase after erase accepted");
   pad_zero_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      s_ff.st == ST_FIELD && s_ff.len != 16'h0000 && !s_ff.have && s_ff.xfer == 16'h0000
      |=> s_ff.have && s_ff.byte_hold == ZERO_BYTE)
      else $error("short transfer not zero filled");
   flag_bit_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      ser_load && s_ff.st == ST_FLAG |-> ser_byte[FLAG_OVF_BIT] == (s_ff.code == WR_OVF))
      else $error("overflow flag bit wrong");
   hdr_len_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      s_ff.st == ST_FIELD && s_ff.fld == FLD_HDR |-> s_ff.len <= HDR_LEN)
      else $error("header field longer than five bytes");
   erase_mark_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      s_ff.erase && s_ff.st != ST_CHK |-> !addr_mark_o && (!ser_load || ser_byte == ZERO_BYTE))
      else $error("erase wrote mark or data");
   trig_pace_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      wr_bit_valid_o |-> $past(bit_trig_i))
      else $error("write bit without trigger pulse");
endmodule // dwc_write_exec

// >>> src/dwc_pkg.sv
// Constants and types shared by the disc write command executor
package dwc_pkg;
   // Command codes, multi-track bit masked off only where is_cmd compares them
   localparam logic [7:0] CMD_MASK = 8'h7F;
   localparam logic [7:0] WR_DATA = 8'h05;
   localparam logic [7:0] WR_KD = 8'h0D;
   localparam logic [7:0] WR_CKD = 8'h1D;
   localparam logic [7:0] WR_OVF = 8'h01;
   localparam logic [7:0] WR_R0 = 8'h15;
   localparam logic [7:0] WR_HDR = 8'h19;
   localparam logic [7:0] ERASE = 8'h11;
   localparam logic [7:0] SRCH_ID_EQ = 8'h31;
   localparam logic [7:0] SRCH_KEY_EQ = 8'h29;
   localparam logic [7:0] SRCH_HDR_EQ = 8'h39;
   localparam logic [7:0] RD_DATA = 8'h06;
   localparam logic [7:0] RD_KD = 8'h0E;
   // Count area layout: bytes left when key and data lengths pass
   localparam logic [15:0] CNT_LEN = 16'h0008;
   localparam logic [15:0] CNT_KEY_LEFT = 16'h0003;
   localparam logic [15:0] CNT_DLH_LEFT = 16'h0002;
   localparam logic [15:0] CNT_DLL_LEFT = 16'h0001;
   localparam logic [15:0] HDR_LEN = 16'h0005;
   localparam int FLAG_OVF_BIT = 4;
   localparam logic [7:0] FLAG_BASE = 8'h00;
   localparam logic [7:0] ZERO_BYTE = 8'h00;
   localparam logic [15:0] ECC_POLY = 16'h1021;
   localparam logic [15:0] ECC_SEED = 16'h0000;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   // Field being written
   typedef enum logic [1:0] {
      FLD_CNT = 2'h0,
      FLD_KEY = 2'h1,
      FLD_DATA = 2'h2,
      FLD_HDR = 2'h3
   } dwc_fld_type;
endpackage

// >>> src/dwc_serializer.sv
// Byte to bit serializer paced by oscillator trigger pulses
`timescale 1ns/1ps
module dwc_serializer
   import dwc_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic trig_i,
   input wire logic load_i,
   input wire logic [7:0] byte_i,
   input wire logic tag_i,
   output logic ready_o,
   output logic bit_o,
   output logic bit_valid_o,
   output logic tag_o
);
   typedef struct packed {
      logic [7:0] sh;
      logic [3:0] cnt;
      logic bit_out;
      logic vld;
      logic tag;
   } dwc_ser_type;
   dwc_ser_type s_ff, nxt_s;

   // Shift one bit per trigger, MSB first
   always_comb begin
      nxt_s = s_ff;
      nxt_s.vld = 1'b0;
      if (load_i && ready_o) begin
         nxt_s.sh = byte_i;
         nxt_s.cnt = BITS_PER_BYTE;
         nxt_s.tag = tag_i;
      end else if (trig_i && s_ff.cnt != 4'h0) begin
         nxt_s.bit_out = s_ff.sh[7];
         nxt_s.vld = 1'b1;
         nxt_s.sh = {s_ff.sh[6:0], 1'b0};
         nxt_s.cnt = s_ff.cnt - 4'h1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         s_ff <= '0;
      end else begin
         s_ff <= nxt_s;
      end
   end

   // Ready only once the last bit has left, so the code sum is final
   assign ready_o = (s_ff.cnt == 4'h0) && !s_ff.vld;
   assign bit_o = s_ff.bit_out;
   assign bit_valid_o = s_ff.vld;
   assign tag_o = s_ff.tag;
endmodule // dwc_serializer

// >>> src/dwc_ecc_gen.sv
// Serial correction code generator over tagged write bits
`timescale 1ns/1ps
module dwc_ecc_gen
   import dwc_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic clr_i,
   input wire logic bit_i,
   input wire logic bit_valid_i,
   input wire logic tag_i,
   output logic [15:0] ecc_o
);
   typedef struct packed {
      logic [15:0] crc;
   } dwc_ecc_type;
   dwc_ecc_type s_ff, nxt_s;

   // Shift register with feedback polynomial
   always_comb begin
      nxt_s = s_ff;
      if (clr_i) begin
         nxt_s.crc = ECC_SEED;
      end else if (bit_valid_i && tag_i) begin
         nxt_s.crc = {s_ff.crc[14:0], 1'b0} ^ ((s_ff.crc[15] ^ bit_i) ? ECC_POLY : 16'h0000);
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         s_ff <= '0;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign ecc_o = s_ff.crc;
endmodule // dwc_ecc_gen

// >>> verif/dwc_host_model.sv
// Host channel model that hands write bytes to the executor on request
`timescale 1ns/1ps
module dwc_host_model (
   input wire logic clk_i,
   input wire logic new_i,
   input wire logic slow_i,
   input wire logic ch_req_i,
   output logic ch_valid_o,
   output logic [7:0] ch_data_o
);
   logic [7:0] mem [16];
   logic [3:0] idx;
   logic [1:0] dly;
   // Quiet start
   initial begin
      ch_valid_o = 1'b0;
      ch_data_o = 8'h00;
      idx = 4'h0;
      dly = 2'h0;
   end
   // One byte per request, optional stall, data inverted once taken
   always @(posedge clk_i) begin
      if (new_i) begin
         idx <= 4'h0;
         ch_valid_o <= 1'b0;
      end else if (ch_valid_o && ch_req_i) begin
         idx <= idx + 4'h1;
         ch_valid_o <= 1'b0;
         ch_data_o <= ~ch_data_o;
      end else if (ch_req_i && (!slow_i || dly == 2'h3)) begin
         ch_valid_o <= 1'b1;
         ch_data_o <= mem[idx];
      end
      dly <= dly + 2'h1;
   end
endmodule // dwc_host_model

// >>> verif/dwc_write_exec_bench.sv
// Self-checking bench for the write command executor
`timescale 1ns/1ps
module dwc_write_exec_bench;
   import dwc_pkg::*;
   typedef struct packed {
      logic [7:0] code;
      logic [15:0] cnt;
      logic [7:0] prev;
      logic [7:0] srch;
      logic match;
      logic mask;
      logic chn;
      logic uc;
   } dwcb_row_type;
   logic clk = 1'b0, rst_n = 1'b0, cmd_v = 1'b0, idx_p = 1'b0, trig = 1'b0, slow = 1'b0;
   logic [7:0] key_length = 8'h00;
   logic [15:0] data_length = 16'h0000;
   logic [8:0] tick = 9'h000;
   logic ch_req, busy, status_valid, chan_end, dev_end, unit_check, wr_gate;
   logic addr_mark, wr_bit, wr_bit_valid, ch_valid, moved;
   logic [7:0] ch_data;
   logic [7:0] exp_q[$], ar_q[$], got_q[$];
   dwcb_row_type cur = '0;
   int num_errors = 0, comparisons = 0, marks;
   dwcb_row_type rows [9] = '{
      '{8'h05, 16'h0001, 8'h06, 8'h31, 1'b1, 1'b0, 1'b1, 1'b1},
      '{8'h05, 16'h0001, 8'h31, 8'h31, 1'b0, 1'b0, 1'b1, 1'b1},
      '{8'h05, 16'h0001, 8'h31, 8'h31, 1'b1, 1'b0, 1'b0, 1'b1},
      '{8'h0D, 16'h0001, 8'h29, 8'h29, 1'b1, 1'b0, 1'b1, 1'b1},
      '{8'h1D, 16'h0008, 8'h06, 8'h31, 1'b0, 1'b0, 1'b1, 1'b1},
      '{8'h01, 16'h0008, 8'h15, 8'h15, 1'b1, 1'b0, 1'b1, 1'b1},
      '{8'h15, 16'h0008, 8'h31, 8'h31, 1'b1, 1'b0, 1'b1, 1'b1},
      '{8'h19, 16'h0005, 8'h00, 8'h00, 1'b0, 1'b0, 1'b1, 1'b1},
      '{8'h11, 16'h0001, 8'h11, 8'h11, 1'b1, 1'b0, 1'b1, 1'b1}};

   dwc_write_exec #(.GAP1_LEN(16'h0002), .SRC_ID(8'h3C)) dut (.clk_i(clk), .rst_n_i(rst_n),
      .cmd_valid_i(cmd_v), .cmd_code_i(cur.code), .cmd_count_i(cur.cnt), .chain_i(cur.chn),
      .chain_prev_i(cur.prev), .chain_srch_i(cur.srch), .chain_match_i(cur.match),
      .file_mask_hdr_i(cur.mask), .rec_key_length_i(key_length), .rec_data_length_i(data_length),
      .ch_valid_i(ch_valid), .ch_data_i(ch_data), .index_i(idx_p), .bit_trig_i(trig),
      .ch_req_o(ch_req), .busy_o(busy), .status_valid_o(status_valid), .chan_end_o(chan_end),
      .dev_end_o(dev_end), .unit_check_o(unit_check), .wr_gate_o(wr_gate),
      .addr_mark_o(addr_mark), .wr_bit_o(wr_bit), .wr_bit_valid_o(wr_bit_valid));
   dwc_host_model host (.clk_i(clk), .new_i(cmd_v), .slow_i(slow), .ch_req_i(ch_req),
      .ch_valid_o(ch_valid), .ch_data_o(ch_data));

   // 200 MHz clock
   always #2.5 clk = ~clk;
   // Trigger every other cycle, index once per 512 cycles
   always @(negedge clk) begin
      trig <= ~trig;
      tick <= tick + 9'h001;
      idx_p <= (tick == 9'h1FF);
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic put(input logic [7:0] b);
      exp_q.push_back(b);
      ar_q.push_back(b);
   endtask
   // Correction bytes of the area collected so far, high byte first
   task automatic ecc();
      logic [15:0] c;
      c = ECC_SEED;
      foreach (ar_q[i]) begin
         c = c ^ {ar_q[i], 8'h00};
         repeat (8) c = c[15] ? ((c << 1) ^ ECC_POLY) : (c << 1);
      end
      exp_q.push_back(c[15:8]);
      exp_q.push_back(c[7:0]);
      ar_q.delete();
   endtask
   task automatic load(input logic [7:0] b [10]);
      foreach (b[i]) host.mem[i] = b[i];
   endtask
   // Issue one command, gather the bit stream up to the status pulse
   task automatic run(input dwcb_row_type r);
      int cyc, nbits, ungated;
      logic [7:0] sh;
      logic fmt;
      cur = r;
      got_q.delete();
      moved = 1'b0;
      marks = 0;
      cyc = 0;
      nbits = 0;
      ungated = 0;
      sh = 8'h00;
      fmt = r.code == WR_CKD || r.code == WR_OVF || r.code == WR_R0;
      cmd_v = 1'b1;
      @(negedge clk);
      cmd_v = 1'b0;
      while (status_valid !== 1'b1 && cyc < 5000) begin
         @(negedge clk);
         cyc++;
         if (ch_req === 1'b1 || wr_gate === 1'b1) moved = 1'b1;
         if (addr_mark === 1'b1) marks++;
         if (wr_bit_valid === 1'b1) begin
            sh = {sh[6:0], wr_bit};
            if (wr_gate !== 1'b1) ungated++;
            if (++nbits % 8 == 0) got_q.push_back(sh);
         end
      end
      chk(16'(status_valid), 16'h0001);
      chk(16'({chan_end, dev_end, unit_check}), r.uc ? 16'h0001 : 16'h0006);
      if (r.uc) begin
         chk(16'(cyc), 16'h0001);
         chk(16'(moved), 16'h0000);
      end else begin
         chk(16'(marks), 16'(fmt));
         chk(16'(ungated), 16'h0000);
      end
      chk(16'(got_q.size()), 16'(exp_q.size()));
      foreach (exp_q[i]) if (i < got_q.size()) chk(16'(got_q[i]), 16'(exp_q[i]));
      exp_q.delete();
      for (int i = 0; i < 3000 && busy !== 1'b0; i++) @(negedge clk);
      chk(16'({busy, wr_gate}), 16'h0000);
   endtask
   task automatic finish_test();
      $display("Comparisons %0d, errors %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // Watchdog
   initial begin
      #100000;
      num_errors++;
      finish_test();
   end
   // Main sequence
   initial begin
      repeat (2) @(negedge clk);
      chk(16'({busy, status_valid, ch_req, wr_gate, wr_bit_valid, addr_mark}), 16'h0000);
      rst_n = 1'b1;
      foreach (rows[i]) run(rows[i]);
      data_length = 16'h0004;
      load('{8'hA1, 8'hB2, 0, 0, 0, 0, 0, 0, 0, 0});
      put(8'hA1); put(8'hB2); put(8'h00); put(8'h00); ecc();
      run('{8'h05, 16'h0002, 8'h31, 8'h31, 1'b1, 1'b0, 1'b1, 1'b0});
      key_length = 8'h02;
      data_length = 16'h0001;
      load('{8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 0, 0, 0, 0, 0});
      put(8'h11); put(8'h22); ecc(); put(8'h33); ecc();
      run('{8'h0D, 16'h0005, 8'h31, 8'h31, 1'b1, 1'b0, 1'b1, 1'b0});
      load('{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h01, 8'h00, 8'h02, 8'hC4, 8'hD5});
      put(8'h00); for (int i = 0; i < 8; i++) put(host.mem[i]); ecc();
      put(8'hC4); ecc(); put(8'hD5); put(8'h00); ecc();
      run('{8'h1D, 16'h000A, 8'h06, 8'h31, 1'b1, 1'b0, 1'b1, 1'b0});
      slow = 1'b1;
      // Overflow segment kept as the last record on its track
      put(8'h10); for (int i = 0; i < 8; i++) put(host.mem[i]); ecc();
      put(8'h00); ecc(); put(8'h00); put(8'h00); ecc();
      run('{8'h01, 16'h0008, 8'h1D, 8'h00, 1'b0, 1'b0, 1'b1, 1'b0});
      // Record zero with an eight byte data field
      load('{8'h00, 8'h01, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00, 8'h08, 0, 0});
      put(8'h00); for (int i = 0; i < 8; i++) put(host.mem[i]); ecc();
      repeat (8) put(8'h00);
      ecc();
      run('{8'h15, 16'h0008, 8'h19, 8'h00, 1'b0, 1'b0, 1'b1, 1'b0});
      slow = 1'b0;
      load('{8'h00, 8'h12, 8'h34, 0, 0, 0, 0, 0, 0, 0});
      exp_q = '{8'h00, 8'h00};
      put(8'h00); put(8'h12); put(8'h34); put(8'h00); put(8'h00); ecc();
      exp_q.push_back(8'h3C);
      run('{8'h19, 16'h0003, 8'h00, 8'h00, 1'b0, 1'b1, 1'b1, 1'b0});
      exp_q = '{8'h00, 8'h00, 8'h00};
      run('{8'h11, 16'h0003, 8'h1D, 8'h00, 1'b0, 1'b0, 1'b1, 1'b0});
      chk(16'(marks), 16'h0000);
      finish_test();
   end
endmodule // dwc_write_exec_bench
